//--- rtl/lcd_pkg.sv
// Purpose: shared constants and types for the display command decoder
// Assumes: 50 MHz core clock, serial pins synchronised inside the top
// Notes:   divider counts are derived from the source rates below
package lcd_pkg;

  // ----------------------------------------
  // rates and derived cycle counts
  // ----------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int SRC_RC_HZ    = 256_000;
  localparam int SRC_XTAL_HZ  = 32_768;
  localparam int SRC_EXT_HZ   = 256_000;
  localparam int TONE_HI_HZ   = 4_000;
  localparam int RATE_TOP_HZ  = 128;

  localparam logic [10:0] RC_TICK_CYC    = 11'(CLK_HZ / SRC_RC_HZ);
  localparam logic [10:0] XTAL_TICK_CYC  = 11'(CLK_HZ / SRC_XTAL_HZ);
  localparam logic [6:0]  RC_TONE_HALF   = 7'(SRC_RC_HZ / (2 * TONE_HI_HZ));
  localparam logic [6:0]  XTAL_TONE_HALF = 7'(SRC_XTAL_HZ / (2 * TONE_HI_HZ));
  localparam logic [6:0]  EXT_TONE_HALF  = 7'(SRC_EXT_HZ / (2 * TONE_HI_HZ));
  localparam logic [10:0] RC_RATE_DIV    = 11'(SRC_RC_HZ / RATE_TOP_HZ);
  localparam logic [10:0] XTAL_RATE_DIV  = 11'(SRC_XTAL_HZ / RATE_TOP_HZ);
  localparam logic [10:0] EXT_RATE_DIV   = 11'(SRC_EXT_HZ / RATE_TOP_HZ);
  localparam logic [2:0]  WDT_TIMEOUT_TICKS = 3'h4;

  // ----------------------------------------
  // serial mode ids and source codes
  // ----------------------------------------
  localparam logic [2:0] ID_READ  = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD   = 3'h4;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_RC   = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CONFIG_OFS  = 8'h00;
  localparam logic [7:0] REG_COMMAND_OFS = 8'h04;
  localparam logic [7:0] REG_FLAGS_OFS   = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic       osc_on;
    logic       bias_on;
    logic       tb_out_en;
    logic       wdt_out_en;
    logic       tone_on;
    logic [1:0] src;
    logic       bias_third;
    logic [1:0] commons;
    logic       tone_low;
    logic       irq_en;
    logic [2:0] rate;
    logic       test_mode;
  } lcd_cfg_t;

  localparam lcd_cfg_t CFG_RESET = '{osc_on: 1'b0, bias_on: 1'b0,
    tb_out_en: 1'b0, wdt_out_en: 1'b0, tone_on: 1'b0, src: SRC_RC,
    bias_third: 1'b0, commons: 2'h2, tone_low: 1'b1, irq_en: 1'b0,
    rate: 3'h7, test_mode: 1'b0};

  typedef enum logic [1:0] {ST_ID, ST_ADDR, ST_DATA, ST_CMD} lcd_ser_st_t;

endpackage

//--- rtl/lcd_cmd_decoder.sv
// Purpose: serial mode and command decoder of a 32x4 segment display driver
// Assumes: host keeps its own timing on the three-wire link
// Notes:   registers over AXI4-Lite mirror the settings
// Function
// R1: read is id 110, 6-bit address msb first, nibble returned lsb first
// R2: write is id 101, address msb first, nibble lsb first, then stored
// R3: read-modify-write uses id 101, read then write the same location
// R4: id 100 selects commands; later commands in the frame carry no id
// R5: command 0000-0000-X stops oscillator and bias generator
// R6: command 0000-0001-X starts the oscillator
// R7: 0000-0010-X turns bias off, 0000-0011-X turns it on
// R8: 0000-0100-X disables time base output, 0000-0110-X enables it
// R9: 0000-0101-X disables watchdog flag output, 0000-0111-X enables it
// R10: 0000-1000-X turns tones off, 0000-1001-X turns them on
// R11: 0000-11XX-X clears the time base counter
// R12: 0000-111X-X clears the watchdog stage
// R13: 0001-01/10/11XX-X pick crystal, internal rc or external clock
// R14: 0010-abX0/1-X pick half or third bias, ab picks 2, 3 or 4 commons
// R15: 010X-XXXX-X sets 4 kHz tone, 011X-XXXX-X sets 2 kHz
// R16: 100X-eXXX-X sets interrupt output enable from bit e
// R17: 101X-X-rrr-X sets time base rate 1 to 128 Hz
// R18: watchdog times out after four ticks of the selected rate
// R19: 1110-0000-X enters test mode, 1110-0011-X returns to normal
// R20: reset gives oscillator, bias, tones off, rc, irq off, 128 Hz, normal
// R21: tone and time base derive from the selected source
// R22: host should reinitialise after power up
// R23: host samples read data between read strobe rise and next fall
// R24: words are nine bits, last ignored; unknown words change nothing
// R25: a word matching both clear patterns clears both counters
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module lcd_cmd_decoder
  import lcd_pkg::*;
#(
  parameter int ADDR_BITS = 6
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // serial link and external clock
  input  wire logic        CS_N,
  input  wire logic        WR_N,
  input  wire logic        RD_N,
  input  wire logic        DATA_IN,
  output logic             DATA_OUT,
  output logic             DATA_OE_N,
  input  wire logic        EXT_CLK,
  // display side
  output lcd_cfg_t         CFG,
  output logic             TONE,
  output logic             TONE_N,
  output logic             IRQ_N,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  if (ADDR_BITS < 2 || ADDR_BITS > 8) begin : g_chk
    $error("ADDR_BITS must lie in 2..8");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [4:0] pin_s3_reg;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      pin_s3_reg <= '1;
    end else begin
      pin_s1_reg <= {EXT_CLK, DATA_IN, RD_N, WR_N, CS_N};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  logic cs_act, wr_rise, wr_fall, rd_fall, din, ext_rise;
  assign cs_act   = !pin_s2_reg[0];
  assign wr_rise  = pin_s2_reg[1] && !pin_s3_reg[1];
  assign wr_fall  = !pin_s2_reg[1] && pin_s3_reg[1];
  assign rd_fall  = !pin_s2_reg[2] && pin_s3_reg[2];
  assign din      = pin_s2_reg[3];
  assign ext_rise = pin_s2_reg[4] && !pin_s3_reg[4];

  // ----------------------------------------
  // serial frame decoder
  // ----------------------------------------
  lcd_ser_st_t            st_reg;
  logic [2:0]             id_reg;
  logic [3:0]             cnt_reg;
  logic [ADDR_BITS-1:0]   addr_reg;
  logic [8:0]             cmd_sh_reg;
  logic [3:0]             nib_reg;
  logic [1:0]             wr_idx_reg;
  logic [1:0]             rd_idx_reg;
  logic                   wr_mode_reg;
  logic                   ser_cmd_v_reg;
  logic [8:0]             ser_cmd_reg;
  logic [3:0]             ram_mem [2**ADDR_BITS];
  logic [2:0]             id_next;
  logic [8:0]             cmd_next;
  logic                   ram_we;

  assign id_next  = {id_reg[1:0], din};
  assign cmd_next = {cmd_sh_reg[7:0], din};
  assign ram_we   = cs_act && wr_rise && st_reg == ST_DATA && wr_mode_reg
                    && wr_idx_reg == 2'h3;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg        <= ST_ID;
      id_reg        <= '0;
      cnt_reg       <= '0;
      addr_reg      <= '0;
      cmd_sh_reg    <= '0;
      nib_reg       <= '0;
      wr_idx_reg    <= '0;
      rd_idx_reg    <= '0;
      wr_mode_reg   <= 1'b0;
      ser_cmd_v_reg <= 1'b0;
      ser_cmd_reg   <= '0;
    end else begin
      ser_cmd_v_reg <= 1'b0;
      if (!cs_act) begin
        // chip select high aborts any partial word
        st_reg  <= ST_ID;
        cnt_reg <= '0;
      end else if (wr_rise) begin
        unique case (st_reg)
          ST_ID: begin
            id_reg  <= id_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h2) begin
              cnt_reg     <= '0;
              wr_mode_reg <= (id_next == ID_WRITE); // R3
              if (id_next == ID_CMD) begin
                st_reg <= ST_CMD; // R4
              end else if (id_next == ID_READ || id_next == ID_WRITE) begin
                st_reg <= ST_ADDR; // R1 R2
              end
            end
          end
          ST_ADDR: begin
            addr_reg <= {addr_reg[ADDR_BITS-2:0], din}; // R1 R2
            cnt_reg  <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(ADDR_BITS - 1)) begin
              cnt_reg    <= '0;
              wr_idx_reg <= '0;
              rd_idx_reg <= '0;
              st_reg     <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (wr_mode_reg) begin
              nib_reg[wr_idx_reg] <= din; // R2
              wr_idx_reg <= wr_idx_reg + 2'h1;
              if (ram_we) begin
                addr_reg   <= addr_reg + 1'b1;
                rd_idx_reg <= '0; // R3
              end
            end
          end
          ST_CMD: begin
            cmd_sh_reg <= cmd_next;
            cnt_reg    <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h8) begin
              // stay in command state: following words carry no id
              cnt_reg       <= '0; // R4
              ser_cmd_v_reg <= 1'b1; // R24
              ser_cmd_reg   <= cmd_next;
            end
          end
        endcase
      end else if (rd_fall && st_reg == ST_DATA) begin
        rd_idx_reg <= rd_idx_reg + 2'h1;
        if (!wr_mode_reg && rd_idx_reg == 2'h3) begin
          addr_reg <= addr_reg + 1'b1; // R1
        end
      end
    end
  end

  // memory carries no reset; contents are undefined until written
  always_ff @(posedge CORE_CLK) begin
    if (ram_we) begin
      ram_mem[addr_reg] <= {din, nib_reg[2:0]}; // R2
    end
  end

  // pin released when the host starts a write strobe or ends the frame
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DATA_OUT  <= 1'b0;
      DATA_OE_N <= 1'b1;
    end else if (!cs_act || wr_fall) begin
      DATA_OE_N <= 1'b1;
    end else if (rd_fall && st_reg == ST_DATA) begin
      DATA_OUT  <= ram_mem[addr_reg][rd_idx_reg]; // R1 R3
      DATA_OE_N <= 1'b0;
    end
  end

  // ----------------------------------------
  // command execution
  // ----------------------------------------
  function automatic lcd_cfg_t apply_cmd(lcd_cfg_t c, logic [8:0] w);
    lcd_cfg_t n;
    n = c;
    if (w[8:5] == 4'h0) begin
      case (w[4:1])
        4'h0: begin
          n.osc_on  = 1'b0; // R5
          n.bias_on = 1'b0;
        end
        4'h1: n.osc_on = 1'b1; // R6
        4'h2: n.bias_on = 1'b0; // R7
        4'h3: n.bias_on = 1'b1; // R7
        4'h4: n.tb_out_en = 1'b0; // R8
        4'h5: n.wdt_out_en = 1'b0; // R9
        4'h6: n.tb_out_en = 1'b1; // R8
        4'h7: n.wdt_out_en = 1'b1; // R9
        4'h8: n.tone_on = 1'b0; // R10
        4'h9: n.tone_on = 1'b1; // R10
        default: n = c; // R24
      endcase
    end else if (w[8:5] == 4'h1) begin
      if (w[4:3] != 2'h0) begin
        n.src = w[4:3]; // R13
      end
    end else if (w[8:5] == 4'h2) begin
      if (w[4:3] != 2'h3) begin
        n.commons    = w[4:3]; // R14
        n.bias_third = w[1];
      end
    end else if (w[8:7] == 2'h1) begin
      n.tone_low = w[6]; // R15
    end else if (w[8:6] == 3'h4) begin
      n.irq_en = w[4]; // R16
    end else if (w[8:6] == 3'h5) begin
      n.rate = w[3:1]; // R17
    end else if (w[8:1] == 8'he0) begin
      n.test_mode = 1'b1; // R19
    end else if (w[8:1] == 8'he3) begin
      n.test_mode = 1'b0; // R19
    end
    return n;
  endfunction

  logic       axi_wr_go;
  logic       axi_cmd_v;
  logic [8:0] axi_cmd_word;
  logic       clr_tb;
  logic       watchdog_clear_cmd;
  lcd_cfg_t   cfg_next;
  logic [8:0] last_cmd_reg;

  assign axi_wr_go    = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  assign axi_cmd_v    = axi_wr_go && S_AXI_AWADDR == REG_COMMAND_OFS
                        && S_AXI_WSTRB[1:0] == 2'h3;
  assign axi_cmd_word = S_AXI_WDATA[8:0];
  // clears leave settings alone; both fire together on 0000-111X
  assign clr_tb  = (ser_cmd_v_reg && ser_cmd_reg[8:3] == 6'h03)
                   || (axi_cmd_v && axi_cmd_word[8:3] == 6'h03); // R11 R25
  assign watchdog_clear_cmd = (ser_cmd_v_reg && ser_cmd_reg[8:2] == 7'h07)
                   || (axi_cmd_v && axi_cmd_word[8:2] == 7'h07); // R12 R25

  // a serial word and a bus word in one cycle are both applied, serial first
  always_comb begin
    cfg_next = CFG;
    if (ser_cmd_v_reg) begin
      cfg_next = apply_cmd(cfg_next, ser_cmd_reg);
    end
    if (axi_cmd_v) begin
      cfg_next = apply_cmd(cfg_next, axi_cmd_word);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      CFG          <= CFG_RESET; // R20
      last_cmd_reg <= '0;
    end else begin
      CFG <= cfg_next;
      if (axi_cmd_v) begin
        last_cmd_reg <= axi_cmd_word;
      end else if (ser_cmd_v_reg) begin
        last_cmd_reg <= ser_cmd_reg;
      end
    end
  end

  // ----------------------------------------
  // clock source, tone, time base, watchdog
  // ----------------------------------------
  logic [10:0] src_cnt_reg;
  logic [10:0] tick_cyc;
  logic [6:0]  tone_half;
  logic [10:0] rate_div;
  logic        src_tick;
  logic [6:0]  tone_cnt_reg;
  logic [10:0] rate_cnt_reg;
  logic        tick128;
  logic [6:0]  tb_reg;
  logic [6:0]  sel_mask;
  logic        sel_tick;
  logic [2:0]  wdt_cnt_reg;
  logic        wdt_flag_reg;

  always_comb begin
    unique case (CFG.src)
      SRC_XTAL: begin
        tick_cyc  = XTAL_TICK_CYC;
        tone_half = XTAL_TONE_HALF;
        rate_div  = XTAL_RATE_DIV;
      end
      SRC_EXT: begin
        tick_cyc  = RC_TICK_CYC;
        tone_half = EXT_TONE_HALF;
        rate_div  = EXT_RATE_DIV;
      end
      default: begin
        tick_cyc  = RC_TICK_CYC;
        tone_half = RC_TONE_HALF;
        rate_div  = RC_RATE_DIV;
      end
    endcase
    if (CFG.tone_low) begin
      tone_half = {tone_half[5:0], 1'b0}; // R15
    end
  end

  // internal sources are modelled by dividing the core clock
  assign src_tick = CFG.osc_on && ((CFG.src == SRC_EXT) ? ext_rise
                    : (src_cnt_reg == tick_cyc - 11'h1)); // R21
  assign tick128  = src_tick && rate_cnt_reg == rate_div - 11'h1; // R21
  assign sel_mask = 7'h7f >> CFG.rate; // R17
  assign sel_tick = tick128 && (tb_reg & sel_mask) == sel_mask;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      src_cnt_reg <= '0;
    end else if (!CFG.osc_on || CFG.src == SRC_EXT || src_tick) begin
      src_cnt_reg <= '0;
    end else begin
      src_cnt_reg <= src_cnt_reg + 11'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tone_cnt_reg <= '0;
      TONE         <= 1'b0;
      TONE_N       <= 1'b0;
    end else if (!(CFG.tone_on && CFG.osc_on)) begin
      tone_cnt_reg <= '0; // R10
      TONE         <= 1'b0;
      TONE_N       <= 1'b0;
    end else if (src_tick) begin
      if (tone_cnt_reg >= tone_half - 7'h1) begin
        tone_cnt_reg <= '0;
        TONE         <= !TONE; // R21
        TONE_N       <= TONE;
      end else begin
        tone_cnt_reg <= tone_cnt_reg + 7'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rate_cnt_reg <= '0;
    end else if (!CFG.osc_on || tick128) begin
      rate_cnt_reg <= '0;
    end else if (src_tick) begin
      rate_cnt_reg <= rate_cnt_reg + 11'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tb_reg <= '0;
    end else if (clr_tb) begin
      tb_reg <= '0; // R11
    end else if (tick128) begin
      tb_reg <= tb_reg + 7'h1;
    end
  end

  // timeout set wins over a clear landing in the same cycle
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      wdt_cnt_reg  <= '0;
      wdt_flag_reg <= 1'b0;
    end else begin
      if (watchdog_clear_cmd) begin
        wdt_cnt_reg <= '0; // R12
      end else if (sel_tick && wdt_cnt_reg != WDT_TIMEOUT_TICKS) begin
        wdt_cnt_reg <= wdt_cnt_reg + 3'h1;
      end
      if (sel_tick && wdt_cnt_reg == WDT_TIMEOUT_TICKS - 3'h1) begin
        wdt_flag_reg <= 1'b1; // R18
      end else if (watchdog_clear_cmd) begin
        wdt_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= !(CFG.irq_en && ((CFG.tb_out_en && sel_tick)
                || (CFG.wdt_out_en && wdt_flag_reg))); // R8 R9 R16
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !S_AXI_AWREADY && !S_AXI_BVALID && S_AXI_AWVALID && S_AXI_WVALID;
      S_AXI_WREADY  <= !S_AXI_AWREADY && !S_AXI_BVALID && S_AXI_AWVALID && S_AXI_WVALID;
      if (axi_wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (S_AXI_AWADDR == REG_COMMAND_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= RESP_OKAY;
        case (S_AXI_ARADDR)
          REG_CONFIG_OFS:  S_AXI_RDATA <= {16'h0000, CFG};
          REG_COMMAND_OFS: S_AXI_RDATA <= {23'h00_0000, last_cmd_reg};
          REG_FLAGS_OFS:   S_AXI_RDATA <= {24'h00_0000, tb_reg, wdt_flag_reg};
          default: begin
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  AST_RESET_DEFAULT: assert property ($past(RESET) |-> CFG == CFG_RESET) // R20
    else $error("settings not at reset values");
  AST_ID_CMD: assert property (cs_act && wr_rise && st_reg == ST_ID && cnt_reg == 4'h2
    && id_next == ID_CMD |=> st_reg == ST_CMD) // R4
    else $error("command id not taken");
  AST_SHUTDOWN: assert property (ser_cmd_v_reg && !axi_cmd_v && ser_cmd_reg[8:1] == 8'h00
    |=> !CFG.osc_on && !CFG.bias_on) // R5
    else $error("shutdown ignored");
  AST_OSC_START: assert property (ser_cmd_v_reg && !axi_cmd_v && ser_cmd_reg[8:1] == 8'h01
    |=> CFG.osc_on) // R6
    else $error("oscillator not started");
  AST_RATE: assert property (ser_cmd_v_reg && !axi_cmd_v && ser_cmd_reg[8:6] == 3'h5
    |=> CFG.rate == ser_cmd_reg[3:1]) // R17
    else $error("rate not taken");
  AST_UNMATCHED: assert property (ser_cmd_v_reg && !axi_cmd_v && ser_cmd_reg[8:2] == 7'h05
    |=> $stable(CFG)) // R24
    else $error("unknown word changed settings");
  AST_BOTH_CLEAR: assert property (watchdog_clear_cmd |-> clr_tb ##1 tb_reg == 7'h00
    && wdt_cnt_reg == 3'h0) // R25
    else $error("clears not both applied");
  AST_WDT_TIMEOUT: assert property (sel_tick && wdt_cnt_reg == 3'h3 |=> wdt_flag_reg) // R18
    else $error("watchdog flag late");
  AST_RAM_INC: assert property (ram_we |=> addr_reg == $past(addr_reg) + 1'b1) // R2
    else $error("address not advanced");
  AST_READ_DRIVE: assert property (cs_act && rd_fall && st_reg == ST_DATA && !wr_fall
    |=> !DATA_OE_N) // R1
    else $error("read data not driven");

  COV_CMD_WORD: cover property (ser_cmd_v_reg ##[1:1000] ser_cmd_v_reg);
  COV_RAM_WRITE: cover property (ram_we);
  COV_WDT_FLAG: cover property ($rose(wdt_flag_reg));

endmodule // lcd_cmd_decoder

`default_nettype wire

//--- testbench/lcd_host_model.sv
// Purpose: host side of the three-wire serial link
// Assumes: write strobes held 4 low and 4 high clocks, read strobes 6 low and 4 high, above the 3 clock minimum
// Notes:   after each bit the data pin shows the inverse, as released hold
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  // core
  input  wire logic clk,
  // serial link
  output logic      cs_n,
  output logic      wr_n,
  output logic      rd_n,
  output logic      data,
  input  wire logic data_out,
  input  wire logic data_oe_n
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data = 1'b0;
  end
  // open (1) or close (0) a frame; host re-sends setup each frame
  task automatic frame(input logic on);
    repeat (8) @(posedge clk);
    cs_n <= ~on;
    repeat (4) @(posedge clk);
  endtask
  // msb first; a command frame carries its id once
  task automatic send(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      data <= v[i];
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      data <= ~v[i];
      @(posedge clk);
    end
  endtask
  // nibble goes lsb first
  task automatic nib(input logic [3:0] d);
    for (int i = 0; i < 4; i++) send({8'h00, d[i]}, 1);
  endtask
  task automatic rd_bit(output logic b, output logic oe);
    rd_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
    b = data_out;
    oe = data_oe_n;
    repeat (2) @(posedge clk);
  endtask
endmodule // lcd_host_model
`default_nettype wire

//--- testbench/lcd_driver_command_decoder_bench.sv
// Purpose: self-checking bench for the display command decoder
// Assumes: 50 MHz clock, serial host model, axi4-lite master tasks
// Notes:   long time base counts are not run, too slow at these rates
`timescale 1ns/10ps
`default_nettype none
module lcd_driver_command_decoder_bench;
  import lcd_pkg::*;
  logic        clk, rst, ext_clk;
  logic        cs_n, wr_n, rd_n, din, dout, doe_n, tone, tone_n, irq_n;
  lcd_cfg_t    cfg, exp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_fail = 0, tests_run = 0;
  logic [8:0]  on_w [12] = '{9'h002, 9'h006, 9'h012, 9'h00C, 9'h00E, 9'h028,
                            9'h04A, 9'h080, 9'h110, 9'h146, 9'h1FF, 9'h1C0};
  logic [8:0]  off_w [12] = '{9'h1C6, 9'h0C0, 9'h008, 9'h00A, 9'h010, 9'h038,
                             9'h100, 9'h016, 9'h01C, 9'h004, 9'h002, 9'h000};
  always #10 clk = ~clk;
  // free-running external source, one rise every two core clocks
  always @(posedge clk) ext_clk <= ~ext_clk;
  lcd_host_model u_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .data(din), .data_out(dout), .data_oe_n(doe_n));
  lcd_cmd_decoder u_lcd_cmd_decoder (.CORE_CLK(clk), .RESET(rst), .CS_N(cs_n),
    .WR_N(wr_n), .RD_N(rd_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n),
    .EXT_CLK(ext_clk), .CFG(cfg), .TONE(tone), .TONE_N(tone_n), .IRQ_N(irq_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) r = bresp;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) {d, r} = {rdata, rresp};
      if (rvalid) rready <= 1'b0;
    end while (!rvalid);
  endtask
  // open a frame with id and 6-bit address
  task automatic acc(input logic [2:0] id);
    u_host.frame(1);
    u_host.send({6'h00, id}, 3);
    u_host.send(9'h02A, 6);
  endtask
  task automatic rd4(output logic [3:0] v);
    logic o;
    for (int i = 0; i < 4; i++) begin
      u_host.rd_bit(v[i], o);
      chk("data_oe_n", 0, 32'(o));
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_cmd();
    chk("cfg reset", 32'(CFG_RESET), 32'(cfg));
    chk("irq_n tone", 32'h3000_0000, {tone, tone_n, irq_n, doe_n, 4'h0, 24'h0});
    u_host.frame(1);
    u_host.send({6'h00, ID_CMD}, 3);
    foreach (on_w[i]) u_host.send(on_w[i], 9);
    u_host.frame(0);
    exp = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, SRC_XTAL, 1'b1, 2'h1, 1'b0, 1'b1, 3'h3, 1'b1};
    chk("cfg on", 32'(exp), 32'(cfg));
    u_host.frame(1);
    u_host.send({6'h00, ID_CMD}, 3);
    foreach (off_w[i]) u_host.send(off_w[i], 9);
    u_host.frame(0);
    exp = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_EXT, 1'b1, 2'h1, 1'b1, 1'b0, 3'h3, 1'b0};
    chk("cfg off", 32'(exp), 32'(cfg));
    $display("commands done");
  endtask
  task automatic t_ram();
    logic [3:0] lo, hi;
    acc(ID_WRITE);
    u_host.nib(4'hA);
    u_host.nib(4'h5);
    u_host.frame(0);
    acc(ID_READ);
    rd4(lo);
    rd4(hi);
    u_host.frame(0);
    chk("ram read", 32'h0000_005A, 32'({hi, lo}));
    acc(ID_WRITE);
    rd4(lo);
    u_host.nib(4'h3);
    u_host.frame(0);
    acc(ID_READ);
    rd4(hi);
    u_host.frame(0);
    chk("rmw", 32'h0000_00A3, 32'({lo, hi}));
    $display("ram done");
  endtask
  task automatic t_axi();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(REG_CONFIG_OFS, d, r);
    chk("cfg reg", {16'h0000, exp}, d);
    axi_wr(REG_COMMAND_OFS, 32'h0000_0002, r);
    repeat (2) @(posedge clk);
    chk("osc_on", 1, 32'(cfg.osc_on));
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    axi_wr(REG_COMMAND_OFS, 32'h0000_0012, r);
    repeat (200) @(posedge clk);
    chk("tone", 32'h0000_0002, 32'({tone, tone_n}));
    wstrb <= 4'h1;
    axi_wr(REG_COMMAND_OFS, 32'h0000_0010, r);
    wstrb <= 4'hF;
    chk("wstrb", 1, 32'(cfg.tone_on));
    axi_rd(REG_COMMAND_OFS, d, r);
    chk("last cmd", 32'h0000_0012, d);
    axi_wr(8'h0C, 32'h0000_0000, r);
    chk("bresp bad", 32'(RESP_SLVERR), 32'(r));
    axi_rd(8'h0C, d, r);
    chk("rdata bad", 0, d ^ 32'(r ^ RESP_SLVERR));
    $display("axi done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, ext_clk} <= '0;
    wstrb <= 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_cmd();
    t_ram();
    t_axi();
    print_verdict();
  end
  // watchdog: tests need about 2700 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // lcd_driver_command_decoder_bench
`default_nettype wire
